// *** verilog/otf_threshold_map.vh ***
/*
  Register offsets, field positions, reset values and timing figures of the
  over-temperature threshold and fault latch block.
  Assumes a 32-bit APB with byte addresses, one word per register.
*/
`ifndef OTF_THRESHOLD_MAP_VH
`define OTF_THRESHOLD_MAP_VH

// register byte offsets
`define OTF_REG_CTRL       8'h00
`define OTF_REG_KSCALE     8'h04
`define OTF_REG_MARGIN     8'h08
`define OTF_REG_PRESS_OVR  8'h0C
`define OTF_REG_TEMPA_OVR  8'h10
`define OTF_REG_THRESH     8'h14
`define OTF_REG_BOIL       8'h18
`define OTF_REG_STATUS     8'h1C

// control fields
`define OTF_CTRL_RESET     0
`define OTF_CTRL_DBG_UNLA  1
`define OTF_CTRL_POVR_EN   2
`define OTF_CTRL_TAOVR_EN  3

// status fields
`define OTF_ST_OK_LSB      0
`define OTF_ST_FAULT       4
`define OTF_ST_BEAM_LF     5
`define OTF_ST_COOL_LF     6
`define OTF_ST_READY       7
`define OTF_ST_OVER_LSB    8

// reset values
`define OTF_KSCALE_RST     12'd3277
`define OTF_MARGIN_RST     12'd246

// temperature scale and pressure range
`define OTF_TEMP_FULL      12'd4095
`define OTF_PRESS_FLOOR    12'd819
`define OTF_PRESS_SPAN     12'd3276

// boiling point fit
`define OTF_BOIL_C3        32'd6312
`define OTF_BOIL_C2        32'd18580
`define OTF_BOIL_C1        32'd45371
`define OTF_BOIL_C0        32'd55246848
`define OTF_BOIL_SH3       7
`define OTF_BOIL_SH2       5
`define OTF_BOIL_SHOUT     15
`define OTF_K_SHIFT        12

// timing
`define OTF_CLK_HZ         250000000
`define OTF_UPDATE_HZ      1000
`define OTF_TICK_CYC       (`OTF_CLK_HZ / `OTF_UPDATE_HZ)
`define OTF_LINK_TMO_US    10000
`define OTF_LINK_TMO_CYC   (`OTF_LINK_TMO_US * (`OTF_CLK_HZ / 1000000))

`endif

// *** verilog/otf_threshold_latch.v ***
/*
  Over-temperature trip threshold and fault latch for four collector
  temperature models, with APB register access.
  Assumes all inputs synchronous to clk; model temperatures are refreshed
  by the model once per update tick; link receivers report packet events.
*/
`timescale 1ns/10ps
`default_nettype none
`include "otf_threshold_map.vh"

module otf_threshold_latch #(
  parameter integer TICK_CYC     = `OTF_TICK_CYC,
  parameter integer LINK_TMO_CYC = `OTF_LINK_TMO_CYC
) (
  input  wire        clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [15:0] modelTempA,
  input  wire [15:0] modelTempB,
  input  wire [15:0] modelTempC,
  input  wire [15:0] modelTempD,
  input  wire [11:0] rawPressure,
  input  wire        supplyFault,
  input  wire        beamPktValid,
  input  wire        beamPktBadAddrSum,
  input  wire        beamPktBadFormat,
  input  wire        coolPktValid,
  input  wire        coolPktBadAddrSum,
  input  wire        coolPktBadFormat,
  output reg         chanATempOk,
  output reg         chanBTempOk,
  output reg         chanCTempOk,
  output reg         chanDTempOk,
  output reg         masterOvertempFault,
  output reg         spareChanAFault
);

  localparam [31:0] TICK_LAST = TICK_CYC - 1;
  localparam [31:0] TMO_LAST  = LINK_TMO_CYC - 1;

  // evaluation sequence
  localparam [1:0] PH_IDLE = 2'd0;
  localparam [1:0] PH_BOIL = 2'd1;
  localparam [1:0] PH_THR  = 2'd2;
  localparam [1:0] PH_CMP  = 2'd3;

  function [11:0] sat12;
    input [15:0] v;
    begin
      sat12 = (v > {4'h0, `OTF_TEMP_FULL}) ? `OTF_TEMP_FULL : v[11:0];
    end
  endfunction

  // unsigned difference floored at zero, never wraps
  function [11:0] subClamp12;
    input [11:0] a;
    input [11:0] b;
    begin
      subClamp12 = (a > b) ? a - b : 12'h000;
    end
  endfunction

  // registers
  reg [11:0] kScale_q;
  reg [11:0] margin_q;
  reg [11:0] pressOvr_q;
  reg [11:0] tempAOvr_q;
  reg        dbgUnlatchA_q;
  reg        pressOvrEn_q;
  reg        tempAOvrEn_q;
  reg        resetCmd_q;

  // evaluation state
  reg [31:0] tickCnt_q;
  reg [1:0]  phase_q;
  reg [11:0] boil_q;
  reg [11:0] thresh_q;
  reg [3:0]  over_q;
  reg [3:0]  ovLatch_q;
  reg        faultLatch_q;
  reg        ready_q;

  // link watchdogs
  reg [31:0] beamTmo_q;
  reg [31:0] coolTmo_q;
  reg        beamBad_q;
  reg        coolBad_q;
  reg        beamLf_q;
  reg        coolLf_q;

  wire       tick = (tickCnt_q == TICK_LAST);
  wire       apbWr = psel & penable & pready & pwrite;

  // pressure and temperatures
  wire [11:0] pressSel = pressOvrEn_q ? pressOvr_q : rawPressure;
  wire [11:0] pressOff = subClamp12(pressSel, `OTF_PRESS_FLOOR);
  wire [11:0] pressN   = (pressOff > `OTF_PRESS_SPAN) ?
                         `OTF_PRESS_SPAN : pressOff;
  wire [11:0] tempA = tempAOvrEn_q ? tempAOvr_q : sat12(modelTempA);
  wire [11:0] tempB = sat12(modelTempB);
  wire [11:0] tempC = sat12(modelTempC);
  wire [11:0] tempD = sat12(modelTempD);

  // boiling point fit, unsigned terms
  wire [31:0] p3   = {20'h0_0000, pressN} >> `OTF_BOIL_SH3;
  wire [31:0] p2   = {20'h0_0000, pressN} >> `OTF_BOIL_SH2;
  wire [31:0] tPos = `OTF_BOIL_C3 * p3 * p3 * p3 +
                     `OTF_BOIL_C1 * {20'h0_0000, pressN} +
                     `OTF_BOIL_C0;
  wire [31:0] tNeg = `OTF_BOIL_C2 * p2 * p2;
  wire [31:0] tSum = (tPos > tNeg) ? tPos - tNeg : 32'h0000_0000;
  wire [31:0] tDiv = tSum >> `OTF_BOIL_SHOUT;
  wire [11:0] boilD = (tDiv > {20'h0_0000, `OTF_TEMP_FULL}) ?
                      `OTF_TEMP_FULL : tDiv[11:0];

  // threshold
  wire [23:0] scaled  = boil_q * kScale_q;
  wire [11:0] scaledT = scaled[23:12];
  wire [11:0] threshD = subClamp12(scaledT, margin_q);

  // comparison against the fresh threshold
  wire [3:0] overD = {tempD > thresh_q, tempC > thresh_q,
                      tempB > thresh_q, tempA > thresh_q};
  wire       cmpNow = (phase_q == PH_CMP);

  // latch next values
  reg [3:0] ovLatch_d;
  reg       faultLatch_d;
  integer   i;
  always @* begin
    ovLatch_d    = ovLatch_q;
    faultLatch_d = faultLatch_q;
    if (resetCmd_q) begin
      ovLatch_d = ovLatch_q & over_q;
      if (~|over_q && !supplyFault)
        faultLatch_d = 1'b0;
    end
    if (cmpNow) begin
      for (i = 0; i < 4; i = i + 1)
        if (overD[i])
          ovLatch_d[i] = 1'b1;
      if (|overD)
        faultLatch_d = 1'b1;
    end
    if (supplyFault)
      faultLatch_d = 1'b1;
    if (dbgUnlatchA_q)
      ovLatch_d[0] = cmpNow ? overD[0] : over_q[0];
  end

  always @(posedge clk) begin
    if (!resetn) begin
      tickCnt_q <= 32'h0000_0000;
      phase_q   <= PH_IDLE;
      boil_q    <= 12'h000;
      thresh_q  <= 12'h000;
      over_q    <= 4'h0;
      ready_q   <= 1'b0;
    end else begin
      tickCnt_q <= tick ? 32'h0000_0000 : tickCnt_q + 32'h0000_0001;
      case (phase_q)
        PH_IDLE: begin
          if (tick)
            phase_q <= PH_BOIL;
        end
        PH_BOIL: begin
          boil_q  <= boilD;
          phase_q <= PH_THR;
        end
        PH_THR: begin
          thresh_q <= threshD;
          phase_q  <= PH_CMP;
        end
        PH_CMP: begin
          over_q  <= overD;
          ready_q <= 1'b1;
          phase_q <= PH_IDLE;
        end
        default: phase_q <= PH_IDLE;
      endcase
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      ovLatch_q    <= 4'h0;
      faultLatch_q <= 1'b0;
    end else begin
      ovLatch_q    <= ovLatch_d;
      faultLatch_q <= faultLatch_d;
    end
  end

  // link fault detection
  always @(posedge clk) begin
    if (!resetn) begin
      beamTmo_q <= 32'h0000_0000;
      coolTmo_q <= 32'h0000_0000;
      beamBad_q <= 1'b0;
      coolBad_q <= 1'b0;
      beamLf_q  <= 1'b1;
      coolLf_q  <= 1'b1;
    end else begin
      if (beamPktValid)
        beamTmo_q <= 32'h0000_0000;
      else if (beamTmo_q != TMO_LAST)
        beamTmo_q <= beamTmo_q + 32'h0000_0001;
      if (coolPktValid)
        coolTmo_q <= 32'h0000_0000;
      else if (coolTmo_q != TMO_LAST)
        coolTmo_q <= coolTmo_q + 32'h0000_0001;
      if (beamPktBadAddrSum || beamPktBadFormat)
        beamBad_q <= 1'b1;
      else if (beamPktValid)
        beamBad_q <= 1'b0;
      if (coolPktBadAddrSum || coolPktBadFormat)
        coolBad_q <= 1'b1;
      else if (coolPktValid)
        coolBad_q <= 1'b0;
      beamLf_q <= beamBad_q || (beamTmo_q == TMO_LAST);
      coolLf_q <= coolBad_q || (coolTmo_q == TMO_LAST);
    end
  end

  // status outputs
  always @(posedge clk) begin
    if (!resetn) begin
      chanATempOk         <= 1'b0;
      chanBTempOk         <= 1'b0;
      chanCTempOk         <= 1'b0;
      chanDTempOk         <= 1'b0;
      masterOvertempFault <= 1'b1;
      spareChanAFault     <= 1'b0;
    end else begin
      chanATempOk <= ready_q & ~ovLatch_q[0] & ~beamLf_q;
      chanBTempOk <= ready_q & ~ovLatch_q[1] & ~beamLf_q;
      chanCTempOk <= ready_q & ~ovLatch_q[2] & ~coolLf_q;
      chanDTempOk <= ready_q & ~ovLatch_q[3] & ~coolLf_q;
      masterOvertempFault <= ~ready_q | faultLatch_q |
                             beamLf_q | coolLf_q;
      spareChanAFault <= dbgUnlatchA_q & over_q[0];
    end
  end

  // APB slave, answer in the first access cycle
  reg [31:0] rdD;
  reg        errD;
  always @* begin
    rdD  = 32'h0000_0000;
    errD = 1'b0;
    case (paddr)
      `OTF_REG_CTRL:
        rdD = {28'h000_0000, tempAOvrEn_q, pressOvrEn_q,
               dbgUnlatchA_q, 1'b0};
      `OTF_REG_KSCALE:    rdD = {20'h0_0000, kScale_q};
      `OTF_REG_MARGIN:    rdD = {20'h0_0000, margin_q};
      `OTF_REG_PRESS_OVR: rdD = {20'h0_0000, pressOvr_q};
      `OTF_REG_TEMPA_OVR: rdD = {20'h0_0000, tempAOvr_q};
      `OTF_REG_THRESH:    rdD = {20'h0_0000, thresh_q};
      `OTF_REG_BOIL:      rdD = {20'h0_0000, boil_q};
      `OTF_REG_STATUS:
        rdD = {20'h0_0000, over_q, ready_q, coolLf_q, beamLf_q,
               masterOvertempFault, chanDTempOk, chanCTempOk,
               chanBTempOk, chanATempOk};
      default: errD = 1'b1;
    endcase
  end

  always @(posedge clk) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & errD;
      if (psel && !penable && !pwrite)
        prdata <= rdD;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      kScale_q      <= `OTF_KSCALE_RST;
      margin_q      <= `OTF_MARGIN_RST;
      pressOvr_q    <= 12'h000;
      tempAOvr_q    <= 12'h000;
      dbgUnlatchA_q <= 1'b0;
      pressOvrEn_q  <= 1'b0;
      tempAOvrEn_q  <= 1'b0;
      resetCmd_q    <= 1'b0;
    end else begin
      resetCmd_q <= 1'b0;
      if (apbWr && !pslverr) begin
        case (paddr)
          `OTF_REG_CTRL: begin
            resetCmd_q    <= pwdata[`OTF_CTRL_RESET];
            dbgUnlatchA_q <= pwdata[`OTF_CTRL_DBG_UNLA];
            pressOvrEn_q  <= pwdata[`OTF_CTRL_POVR_EN];
            tempAOvrEn_q  <= pwdata[`OTF_CTRL_TAOVR_EN];
          end
          `OTF_REG_KSCALE:    kScale_q   <= pwdata[11:0];
          `OTF_REG_MARGIN:    margin_q   <= pwdata[11:0];
          `OTF_REG_PRESS_OVR: pressOvr_q <= pwdata[11:0];
          `OTF_REG_TEMPA_OVR: tempAOvr_q <= pwdata[11:0];
          default: resetCmd_q <= 1'b0;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// *** bench/otf_threshold_checker.sv ***
/* port assertions for the threshold and fault latch block.
   bound onto otf_threshold_latch; one clock, sync active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module otf_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supplyFault,
  input wire logic beamPktValid,
  input wire logic beamPktBadFormat,
  input wire logic coolPktValid,
  input wire logic coolPktBadAddrSum,
  input wire logic chanATempOk,
  input wire logic chanBTempOk,
  input wire logic chanCTempOk,
  input wire logic chanDTempOk,
  input wire logic masterOvertempFault
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire allOk = chanATempOk & chanBTempOk & chanCTempOk & chanDTempOk;
  wire anyOk = chanATempOk | chanBTempOk | chanCTempOk | chanDTempOk;
  sequence beamBad;
    beamPktBadFormat ##1 !beamPktValid [*4];
  endsequence
  sequence coolBad;
    coolPktBadAddrSum ##1 !coolPktValid [*4];
  endsequence
  chk_ready_zero: assert property (psel && !penable |=> pready)
    else $error("no pready in access cycle");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_reset_out: assert property (
    $rose(resetn) |-> !anyOk && masterOvertempFault)
    else $error("outputs not safe after reset");
  chk_fault_clear: assert property (
    $fell(masterOvertempFault) |-> ##[0:1] allOk)
    else $error("fault cleared with channel down");
  chk_supply_set: assert property (
    supplyFault |-> ##[1:3] masterOvertempFault)
    else $error("supply fault not seen");
  chk_beam_force: assert property (
    beamBad |-> !chanATempOk && !chanBTempOk && masterOvertempFault)
    else $error("beam link fault not forced");
  chk_cool_force: assert property (
    coolBad |-> !chanCTempOk && !chanDTempOk && masterOvertempFault)
    else $error("cooling link fault not forced");
endmodule
bind otf_threshold_latch otf_checker otf_checker_i (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .supplyFault(supplyFault),
  .beamPktValid(beamPktValid), .beamPktBadFormat(beamPktBadFormat),
  .coolPktValid(coolPktValid), .coolPktBadAddrSum(coolPktBadAddrSum),
  .chanATempOk(chanATempOk), .chanBTempOk(chanBTempOk),
  .chanCTempOk(chanCTempOk), .chanDTempOk(chanDTempOk),
  .masterOvertempFault(masterOvertempFault)
);
`default_nettype wire

// *** bench/otf_hv_model.sv ***
/* hard-fault partner model of the main board.
   assumes shotEnd marks the end of a shot, same clock as the block. */
`timescale 1ns/10ps
`default_nettype none
module otf_hv_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic shotEnd,
  input  wire logic masterOvertempFault,
  output wire logic hvOff
);
  logic hvHeld_q;
  // drop high voltage at once, hold it to shot end
  assign hvOff = masterOvertempFault | hvHeld_q;
  always @(posedge clk) begin
    if (!resetn || shotEnd)
      hvHeld_q <= 1'b0;
    else if (masterOvertempFault)
      hvHeld_q <= 1'b1;
  end
endmodule
`default_nettype wire

// *** bench/tb_overtemp_fault_threshold_latch.sv ***
/* testbench: APB master tasks, link packet source, hard-fault model.
   assumes the map header; short tick and link timeout parameters. */
`timescale 1ns/10ps
`default_nettype none
`include "otf_threshold_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_overtemp_fault_threshold_latch;
  localparam int TICK = 20;
  localparam int TMO  = 100;
  logic        clk = '0, resetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [15:0] tempA = '0, tempB = '0, tempC = '0, tempD = '0;
  logic [11:0] rawPressure = 12'h333;
  logic [3:0]  badPulse = '0;
  logic [4:0]  linkCnt = '0;
  logic        supplyFault = '0, shotEnd = '0, beamOn = '1, coolOn = '1;
  logic        beamValid = '0, coolValid = '0;
  logic        pready, pslverr, okA, okB, okC, okD, fault, spare, hvOff;
  logic        rdErr;
  logic [31:0] prdata, rdData, th;
  int          num_errors = 0, checks_done = 0;
  logic [11:0] pr [3] = '{12'h333, 12'h5DC, 12'hFFF};

  otf_threshold_latch #(.TICK_CYC(TICK), .LINK_TMO_CYC(TMO))
    otf_threshold_latch_i (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .modelTempA(tempA),
    .modelTempB(tempB), .modelTempC(tempC), .modelTempD(tempD),
    .rawPressure(rawPressure), .supplyFault(supplyFault),
    .beamPktValid(beamValid), .beamPktBadAddrSum(badPulse[0]),
    .beamPktBadFormat(badPulse[1]), .coolPktValid(coolValid),
    .coolPktBadAddrSum(badPulse[2]), .coolPktBadFormat(badPulse[3]),
    .chanATempOk(okA), .chanBTempOk(okB), .chanCTempOk(okC),
    .chanDTempOk(okD), .masterOvertempFault(fault), .spareChanAFault(spare)
  );
  otf_hv_model otf_hv_model_i (
    .clk(clk), .resetn(resetn), .shotEnd(shotEnd),
    .masterOvertempFault(fault), .hvOff(hvOff)
  );

  initial begin
    forever #2 clk = ~clk;
  end
  // one good packet per link every 32 cycles while enabled
  always @(posedge clk) begin
    linkCnt <= linkCnt + 5'h01;
    beamValid <= beamOn && linkCnt == 5'h00;
    coolValid <= coolOn && linkCnt == 5'h00;
  end

  function automatic logic [31:0] expBoil(input logic [11:0] raw);
    logic [31:0] n, a, b;
    n = raw - 32'h0000_0333;
    a = n >> 7;
    b = n >> 5;
    return (32'h0000_18A8 * a * a * a - 32'h0000_4894 * b * b
            + 32'h0000_B13B * n + 32'h034B_0000) >> 15;
  endfunction
  function automatic logic [31:0] expTh(input logic [11:0] raw, k, m);
    logic [31:0] s;
    s = (expBoil(raw) * k) >> 12;
    return (s > m) ? s - m : 32'h0000_0000;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      report_and_stop();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdData, e)
  endtask
  task automatic evalWait();
    repeat (2 * TICK + 8) @(posedge clk);
  endtask
  task automatic okChk(input logic [4:0] e);
    #1;
    `CHK({okA, okB, okC, okD, fault}, e)
  endtask
  task automatic pulseBad(input int i);
    @(posedge clk);
    badPulse <= 4'h1 << i;
    @(posedge clk);
    badPulse <= 4'h0;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (TICK) @(posedge clk);
    okChk(5'h01);
    evalWait();
    okChk(5'h1E);
    rdChk(`OTF_REG_STATUS, 32'h0000_008F);
    rdChk(`OTF_REG_KSCALE, 32'h0000_0CCD);
    rdChk(`OTF_REG_MARGIN, 32'h0000_00F6);
    rdChk(8'h20, 32'h0000_0000);
    `CHK(rdErr, 1'b1)
    foreach (pr[i]) begin
      @(posedge clk);
      rawPressure <= pr[i];
      evalWait();
      rdChk(`OTF_REG_BOIL, expBoil(pr[i]));
      rdChk(`OTF_REG_THRESH, expTh(pr[i], 12'hCCD, 12'h0F6));
    end
    wr(`OTF_REG_KSCALE, 32'h0000_0FFF);
    wr(`OTF_REG_MARGIN, 32'h0000_0FFF);
    rdChk(`OTF_REG_KSCALE, 32'h0000_0FFF);
    evalWait();
    rdChk(`OTF_REG_THRESH, 32'h0000_0000);
    wr(`OTF_REG_KSCALE, 32'h0000_0CCD);
    wr(`OTF_REG_MARGIN, 32'h0000_00F6);
    evalWait();
    $display("test threshold done");
    th = expTh(12'h333, 12'hCCD, 12'h0F6);
    @(posedge clk);
    shotEnd <= 1'b1;
    rawPressure <= 12'h333;
    tempA <= th[15:0] + 16'h0001;
    tempB <= th[15:0];
    tempC <= 16'h1000;
    @(posedge clk);
    shotEnd <= 1'b0;
    evalWait();
    okChk(5'h0B);
    @(posedge clk);
    tempA <= 16'h0000;
    evalWait();
    okChk(5'h0B);
    wr(`OTF_REG_CTRL, 32'h0000_0001);
    evalWait();
    okChk(5'h1B);
    @(posedge clk);
    tempC <= 16'h0000;
    evalWait();
    wr(`OTF_REG_CTRL, 32'h0000_0001);
    evalWait();
    okChk(5'h1E);
    `CHK(hvOff, 1'b1)
    @(posedge clk);
    supplyFault <= 1'b1;
    repeat (4) @(posedge clk);
    supplyFault <= 1'b0;
    evalWait();
    okChk(5'h1F);
    wr(`OTF_REG_CTRL, 32'h0000_0001);
    evalWait();
    okChk(5'h1E);
    $display("test latches done");
    wr(`OTF_REG_PRESS_OVR, 32'h0000_0FFF);
    wr(`OTF_REG_TEMPA_OVR, 32'h0000_0FFF);
    wr(`OTF_REG_CTRL, 32'h0000_000E);
    rdChk(`OTF_REG_CTRL, 32'h0000_000E);
    evalWait();
    rdChk(`OTF_REG_BOIL, expBoil(12'hFFF));
    `CHK({spare, okA}, 2'b10)
    wr(`OTF_REG_TEMPA_OVR, 32'h0000_0000);
    evalWait();
    `CHK({spare, okA}, 2'b01)
    wr(`OTF_REG_CTRL, 32'h0000_000A);
    evalWait();
    rdChk(`OTF_REG_BOIL, expBoil(12'h333));
    wr(`OTF_REG_CTRL, 32'h0000_0000);
    wr(`OTF_REG_CTRL, 32'h0000_0001);
    evalWait();
    okChk(5'h1E);
    $display("test debug done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      beamOn <= (i > 1);
      coolOn <= (i < 2);
      pulseBad(i);
      repeat (4) @(posedge clk);
      okChk((i < 2) ? 5'h07 : 5'h19);
      @(posedge clk);
      beamOn <= 1'b1;
      coolOn <= 1'b1;
      repeat (40) @(posedge clk);
      okChk(5'h1E);
    end
    @(posedge clk);
    coolOn <= 1'b0;
    repeat (TMO + 40) @(posedge clk);
    okChk(5'h19);
    @(posedge clk);
    coolOn <= 1'b1;
    repeat (40) @(posedge clk);
    okChk(5'h1E);
    $display("test links done");
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
